// ==== rtl/accumulator_alu_ops.sv ====
// accumulator alu datapath with pointer adder and axi4-lite register access
//
// Summary of operation
// - pointer add sign-extends a 6-bit literal onto a 16-bit pointer, flags untouched.
// - pointer sum wraps modulo 65536 across both bounds.
// - and-immediate ands accumulator with 8-bit literal, updates zero only.
// - add-immediate adds 8-bit literal to accumulator, updates carry, digit carry, zero.
// - and-register ands accumulator with register; dest bit picks accumulator or register.
// - add-register adds accumulator and register, updates c, dc, z; dest selects target.
// - arithmetic shift right keeps msb, bit 0 to carry, updates c and z.
// - add with carry sums accumulator, register and carry; updates c, dc, z.
// - bit clear zeroes one selected register bit, flags untouched.
`timescale 1ns/1ps
module accumulator_alu_ops #(
   parameter int NUM_PTR = alu_pkg::NUM_PTR
) (
   input  wire  logic                            clk_i,
   input  wire  logic                            sys_rst_i,
   // decoder side
   input  wire  logic                            op_valid_i,
   input  wire  alu_pkg::op_req_t                op_req_i,
   output logic [alu_pkg::FADDR_W-1:0]           mem_raddr_o,
   input  wire  logic [alu_pkg::DATA_W-1:0]      mem_rdata_i,
   output logic                                  mem_we_o,
   output logic [alu_pkg::FADDR_W-1:0]           mem_waddr_o,
   output logic [alu_pkg::DATA_W-1:0]            mem_wdata_o,
   output logic [alu_pkg::DATA_W-1:0]            acc_o,
   output logic                                  carry_flag_o,
   output logic                                  digit_carry_flag_o,
   output logic                                  zero_flag_o,
   output logic [alu_pkg::PTR_W-1:0]             indirect_pointer_o [NUM_PTR],
   // axi4-lite slave
   input  wire  logic [7:0]                      s_axi_awaddr,
   input  wire  logic                            s_axi_awvalid,
   output logic                                  s_axi_awready,
   input  wire  logic [31:0]                     s_axi_wdata,
   input  wire  logic [3:0]                      s_axi_wstrb,
   input  wire  logic                            s_axi_wvalid,
   output logic                                  s_axi_wready,
   output logic [1:0]                            s_axi_bresp,
   output logic                                  s_axi_bvalid,
   input  wire  logic                            s_axi_bready,
   input  wire  logic [7:0]                      s_axi_araddr,
   input  wire  logic                            s_axi_arvalid,
   output logic                                  s_axi_arready,
   output logic [31:0]                           s_axi_rdata,
   output logic [1:0]                            s_axi_rresp,
   output logic                                  s_axi_rvalid,
   input  wire  logic                            s_axi_rready
);

   // **********
   // state
   // **********
   logic [7:0]  acc_q;
   logic        c_q, dc_q, z_q;
   logic [15:0] ptr_q [NUM_PTR];
   logic [15:0] opcnt_q;
   logic        mem_we_q;
   logic [6:0]  mem_waddr_q;
   logic [7:0]  mem_wdata_q;
   alu_pkg::alu_res_t res;
   logic        op_go;
   logic        ptr_op;
   logic [15:0] ptr_ext;

   // axi write/read bookkeeping
   logic        aw_full_q, w_full_q, bvalid_q, rvalid_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic        bus_wr;

   // **********
   // operation decode
   // **********
   // the register is read in the issue cycle through the file address
   assign mem_raddr_o = op_req_i.file_addr;
   assign op_go       = op_valid_i && (op_req_i.op != alu_pkg::OP_NONE);
   assign ptr_op      = op_valid_i && (op_req_i.op == alu_pkg::OP_POINTER_ADD_LITERAL);
   // 6-bit literal sign-extended to pointer width
   assign ptr_ext     = {{10{op_req_i.literal[5]}}, op_req_i.literal[5:0]};

   alu_byte_unit u_byte (
      .req_i   (op_req_i),
      .acc_i   (acc_q),
      .reg_i   (mem_rdata_i),
      .carry_i (c_q),
      .res_o   (res)
   );

   assign bus_wr = aw_full_q && w_full_q && !bvalid_q;

   // **********
   // accumulator: an issued operation wins over a bus write
   // **********
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         acc_q <= alu_pkg::ACC_RST;
      end else if (op_valid_i && res.wr_acc) begin
         acc_q <= res.value;
      end else if (bus_wr && awaddr_q == alu_pkg::ACC_OFF && wstrb_q[0]) begin
         acc_q <= wdata_q[7:0];
      end
   end

   // **********
   // status flags: an operation updates only those it names; a status bus write loads all three
   // **********
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         c_q  <= alu_pkg::FLAG_RST;
         dc_q <= alu_pkg::FLAG_RST;
         z_q  <= alu_pkg::FLAG_RST;
      end else if (op_go && !ptr_op) begin
         if (res.upd_c) begin
            c_q <= res.carry;
         end
         if (res.upd_dc) begin
            dc_q <= res.digit_carry;
         end
         if (res.upd_z) begin
            z_q <= res.zero;
         end
      end else if (bus_wr && awaddr_q == alu_pkg::STATUS_OFF && wstrb_q[0]) begin
         c_q  <= wdata_q[alu_pkg::STAT_C_BIT];
         dc_q <= wdata_q[alu_pkg::STAT_DC_BIT];
         z_q  <= wdata_q[alu_pkg::STAT_Z_BIT];
      end
   end

   // **********
   // indirect pointers
   // **********
   // 16-bit sum drops the carry, so both bounds wrap naturally
   for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
      always_ff @(posedge clk_i) begin
         if (sys_rst_i) begin
            ptr_q[i] <= alu_pkg::PTR_RST;
         end else if (ptr_op && op_req_i.ptr_sel == 1'(i)) begin
            ptr_q[i] <= ptr_q[i] + ptr_ext;
         end else if (bus_wr && awaddr_q == (alu_pkg::PTR0_OFF + 8'(4 * i))) begin
            if (wstrb_q[0]) begin
               ptr_q[i][7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
               ptr_q[i][15:8] <= wdata_q[15:8];
            end
         end
      end
      assign indirect_pointer_o[i] = ptr_q[i];
   end

   // **********
   // data memory write-back, one cycle after issue
   // **********
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mem_we_q    <= 1'b0;
         mem_waddr_q <= 7'h00;
         mem_wdata_q <= 8'h00;
      end else begin
         mem_we_q <= op_valid_i && res.wr_reg;
         if (op_valid_i && res.wr_reg) begin
            mem_waddr_q <= op_req_i.file_addr;
            mem_wdata_q <= res.value;
         end
      end
   end

   // completed operation counter, visible to software
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         opcnt_q <= 16'h0000;
      end else if (op_go) begin
         opcnt_q <= opcnt_q + 16'h0001;
      end
   end

   // **********
   // axi4-lite write channel
   // **********
   // address and data are caught separately, in either order
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (bus_wr) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (bus_wr) begin
            w_full_q <= 1'b0;
         end
      end
   end

   // write response; the op counter is read only and answers slverr
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         bvalid_q <= 1'b0;
         bresp_q  <= alu_pkg::RESP_OKAY;
      end else if (bus_wr) begin
         bvalid_q <= 1'b1;
         unique case (awaddr_q)
            alu_pkg::ACC_OFF, alu_pkg::STATUS_OFF,
            alu_pkg::PTR0_OFF, alu_pkg::PTR1_OFF: bresp_q <= alu_pkg::RESP_OKAY;
            default:                             bresp_q <= alu_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // **********
   // axi4-lite read channel
   // **********
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= alu_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= alu_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            alu_pkg::ACC_OFF:    rdata_q <= {24'h000000, acc_q};
            alu_pkg::STATUS_OFF: rdata_q <= {29'h0, z_q, dc_q, c_q};
            alu_pkg::PTR0_OFF:   rdata_q <= {16'h0000, ptr_q[0]};
            alu_pkg::PTR1_OFF:   rdata_q <= {16'h0000, ptr_q[NUM_PTR-1]};
            alu_pkg::OPCNT_OFF:  rdata_q <= {16'h0000, opcnt_q};
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= alu_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // **********
   // outputs
   // **********
   assign s_axi_awready      = !aw_full_q;
   assign s_axi_wready       = !w_full_q;
   assign s_axi_bvalid       = bvalid_q;
   assign s_axi_bresp        = bresp_q;
   assign s_axi_arready      = !rvalid_q;
   assign s_axi_rvalid       = rvalid_q;
   assign s_axi_rdata        = rdata_q;
   assign s_axi_rresp        = rresp_q;
   assign mem_we_o           = mem_we_q;
   assign mem_waddr_o        = mem_waddr_q;
   assign mem_wdata_o        = mem_wdata_q;
   assign acc_o              = acc_q;
   assign carry_flag_o       = c_q;
   assign digit_carry_flag_o = dc_q;
   assign zero_flag_o        = z_q;

endmodule

// ==== rtl/alu_byte_unit.sv ====
// combinational byte arithmetic for the accumulator and register operations
`timescale 1ns/1ps
module alu_byte_unit (
   input  wire alu_pkg::op_req_t  req_i,
   input  wire logic [7:0]        acc_i,
   input  wire logic [7:0]        reg_i,
   input  wire logic              carry_i,
   output alu_pkg::alu_res_t      res_o
);

   // **********
   // shared adder
   // **********
   logic [7:0] add_b;
   logic       add_cin;
   logic [8:0] sum9;
   logic [4:0] sum5;

   // one adder serves the three additions; operand b is literal or register
   always_comb begin
      add_b   = (req_i.op == alu_pkg::OP_ADD_IMMEDIATE_ACC) ? req_i.literal : reg_i;
      add_cin = (req_i.op == alu_pkg::OP_ADD_ACC_REG_CARRY) ? carry_i : 1'b0;
      sum9    = {1'b0, acc_i} + {1'b0, add_b} + {8'h00, add_cin};
      sum5    = {1'b0, acc_i[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
   end

   // **********
   // result selection
   // **********
   always_comb begin
      res_o             = '0;
      res_o.carry       = sum9[8];
      res_o.digit_carry = sum5[4];
      unique case (req_i.op)
         alu_pkg::OP_AND_IMMEDIATE_ACC: begin
            res_o.value  = acc_i & req_i.literal;
            res_o.upd_z  = 1'b1;
            res_o.wr_acc = 1'b1;
         end
         alu_pkg::OP_ADD_IMMEDIATE_ACC: begin
            res_o.value  = sum9[7:0];
            res_o.upd_c  = 1'b1;
            res_o.upd_dc = 1'b1;
            res_o.upd_z  = 1'b1;
            res_o.wr_acc = 1'b1;
         end
         alu_pkg::OP_AND_ACC_REGISTER: begin
            res_o.value  = acc_i & reg_i;
            res_o.upd_z  = 1'b1;
            res_o.wr_acc = ~req_i.dest;
            res_o.wr_reg = req_i.dest;
         end
         alu_pkg::OP_ADD_ACC_REGISTER,
         alu_pkg::OP_ADD_ACC_REG_CARRY: begin
            res_o.value  = sum9[7:0];
            res_o.upd_c  = 1'b1;
            res_o.upd_dc = 1'b1;
            res_o.upd_z  = 1'b1;
            res_o.wr_acc = ~req_i.dest;
            res_o.wr_reg = req_i.dest;
         end
         alu_pkg::OP_ARITH_SHIFT_RIGHT: begin
            res_o.value  = {reg_i[7], reg_i[7:1]};
            res_o.carry  = reg_i[0];
            res_o.upd_c  = 1'b1;
            res_o.upd_z  = 1'b1;
            res_o.wr_acc = ~req_i.dest;
            res_o.wr_reg = req_i.dest;
         end
         alu_pkg::OP_CLEAR_REGISTER_BIT: begin
            // flags untouched, only the chosen bit drops
            res_o.value  = reg_i & ~(8'h01 << req_i.bit_idx);
            res_o.wr_reg = 1'b1;
         end
         default: begin
            res_o.value = 8'h00;
         end
      endcase
      res_o.zero = (res_o.value == 8'h00);
   end

endmodule

// ==== rtl/alu_pkg.sv ====
// package: opcodes, carriers and register map of the accumulator alu datapath
package alu_pkg;

   // **********
   // widths and operand ranges
   // **********
   localparam int DATA_W      = 8;
   localparam int PTR_W       = 16;
   localparam int FADDR_W     = 7;   // 128 locations in the current bank
   localparam int PLIT_W      = 6;   // signed pointer literal, -32..31
   localparam int NUM_PTR     = 2;

   // **********
   // register map (byte addresses, one word each)
   // **********
   localparam logic [7:0] ACC_OFF    = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] PTR0_OFF   = 8'h08;
   localparam logic [7:0] PTR1_OFF   = 8'h0c;
   localparam logic [7:0] OPCNT_OFF  = 8'h10;

   // status register field positions
   localparam int STAT_C_BIT  = 0;
   localparam int STAT_DC_BIT = 1;
   localparam int STAT_Z_BIT  = 2;

   // reset values
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [PTR_W-1:0]  PTR_RST = 16'h0000;
   localparam logic              FLAG_RST = 1'b0;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // **********
   // operations
   // **********
   typedef enum logic [3:0] {
      OP_NONE                = 4'h0,
      OP_POINTER_ADD_LITERAL = 4'h1,
      OP_AND_IMMEDIATE_ACC   = 4'h2,
      OP_ADD_IMMEDIATE_ACC   = 4'h3,
      OP_AND_ACC_REGISTER    = 4'h4,
      OP_ADD_ACC_REGISTER    = 4'h5,
      OP_ARITH_SHIFT_RIGHT   = 4'h6,
      OP_ADD_ACC_REG_CARRY   = 4'h7,
      OP_CLEAR_REGISTER_BIT  = 4'h8
   } op_t;

   // request from the instruction decoder
   typedef struct packed {
      op_t                  op;
      logic [DATA_W-1:0]    literal;   // 8-bit immediate, low 6 bits for pointer add
      logic [FADDR_W-1:0]   file_addr;
      logic                 dest;      // 0: accumulator, 1: register
      logic [2:0]           bit_idx;
      logic                 ptr_sel;
   } op_req_t;

   // result of one byte operation
   typedef struct packed {
      logic [DATA_W-1:0] value;
      logic              carry;
      logic              digit_carry;
      logic              zero;
      logic              upd_c;
      logic              upd_dc;
      logic              upd_z;
      logic              wr_acc;
      logic              wr_reg;
   } alu_res_t;

endpackage

// ==== tb/accumulator_alu_ops_sva.sv ====
// assertion checker for the accumulator alu datapath, bound to its top module
`timescale 1ns/1ps
module accumulator_alu_ops_sva #(
   parameter int NUM_PTR = alu_pkg::NUM_PTR
) (
   input wire logic                        clk_i,
   input wire logic                        sys_rst_i,
   input wire logic                        op_valid_i,
   input wire alu_pkg::op_req_t            op_req_i,
   input wire logic [alu_pkg::DATA_W-1:0]  mem_rdata_i,
   input wire logic                        mem_we_o,
   input wire logic [alu_pkg::FADDR_W-1:0] mem_waddr_o,
   input wire logic [alu_pkg::DATA_W-1:0]  mem_wdata_o,
   input wire logic [alu_pkg::DATA_W-1:0]  acc_o,
   input wire logic                        carry_flag_o,
   input wire logic                        digit_carry_flag_o,
   input wire logic                        zero_flag_o,
   input wire logic [alu_pkg::PTR_W-1:0]   indirect_pointer_o [NUM_PTR],
   input wire logic                        s_axi_bvalid
);
   alu_pkg::op_t op;
   logic [8:0]   sum_lit, sum_reg, asr_val;
   logic [7:0]   and_lit, and_reg, clr_val;
   logic [15:0]  sext;
   logic [6:0]   fa;
   logic         cin, dc_lit, dc_reg, wr_req;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // results expected from the operands seen at the issue edge
   assign op      = op_req_i.op;
   assign fa      = op_req_i.file_addr;
   assign cin     = (op == alu_pkg::OP_ADD_ACC_REG_CARRY) & carry_flag_o;
   assign sum_lit = {1'b0, acc_o} + {1'b0, op_req_i.literal};
   assign sum_reg = {1'b0, acc_o} + {1'b0, mem_rdata_i} + {8'h00, cin};
   assign dc_lit  = ({1'b0, acc_o[3:0]} + {1'b0, op_req_i.literal[3:0]}) > 5'h0f;
   assign dc_reg  = ({1'b0, acc_o[3:0]} + {1'b0, mem_rdata_i[3:0]} + {4'h0, cin}) > 5'h0f;
   assign asr_val = {mem_rdata_i[0], mem_rdata_i[7], mem_rdata_i[7:1]};
   assign and_lit = acc_o & op_req_i.literal;
   assign and_reg = acc_o & mem_rdata_i;
   assign clr_val = mem_rdata_i & ~(8'h01 << op_req_i.bit_idx);
   assign sext    = {{10{op_req_i.literal[5]}}, op_req_i.literal[5:0]};
   assign wr_req  = op_valid_i && (op == alu_pkg::OP_CLEAR_REGISTER_BIT
                    || (op_req_i.dest && op >= alu_pkg::OP_AND_ACC_REGISTER && op <= alu_pkg::OP_ADD_ACC_REG_CARRY));

   ptr0_add_a: assert property (op_valid_i && op == alu_pkg::OP_POINTER_ADD_LITERAL && !op_req_i.ptr_sel
      |=> indirect_pointer_o[0] == $past(indirect_pointer_o[0]) + $past(sext)) else $error("pointer 0 sum wrong");
   ptr1_add_a: assert property (op_valid_i && op == alu_pkg::OP_POINTER_ADD_LITERAL && op_req_i.ptr_sel
      |=> indirect_pointer_o[1] == $past(indirect_pointer_o[1]) + $past(sext)) else $error("pointer 1 sum wrong");
   flags_keep_a: assert property (op_valid_i && (op == alu_pkg::OP_POINTER_ADD_LITERAL
      || op == alu_pkg::OP_CLEAR_REGISTER_BIT) |=> $stable({carry_flag_o, digit_carry_flag_o, zero_flag_o})
      || $rose(s_axi_bvalid)) else $error("flags moved");
   and_imm_a: assert property (op_valid_i && op == alu_pkg::OP_AND_IMMEDIATE_ACC |=> acc_o == $past(and_lit)
      && zero_flag_o == (acc_o == 8'h00) && $stable({carry_flag_o, digit_carry_flag_o})) else $error("and imm");
   add_imm_a: assert property (op_valid_i && op == alu_pkg::OP_ADD_IMMEDIATE_ACC
      |=> {carry_flag_o, acc_o} == $past(sum_lit) && digit_carry_flag_o == $past(dc_lit)
      && zero_flag_o == (acc_o == 8'h00)) else $error("add imm");
   and_reg_a: assert property (op_valid_i && op == alu_pkg::OP_AND_ACC_REGISTER && !op_req_i.dest
      |=> acc_o == $past(and_reg) && !mem_we_o) else $error("and reg");
   add_acc_a: assert property (op_valid_i && !op_req_i.dest && (op == alu_pkg::OP_ADD_ACC_REGISTER
      || op == alu_pkg::OP_ADD_ACC_REG_CARRY) |=> {carry_flag_o, acc_o} == $past(sum_reg)
      && digit_carry_flag_o == $past(dc_reg) && zero_flag_o == (acc_o == 8'h00)) else $error("add to acc");
   add_back_a: assert property (op_valid_i && op_req_i.dest && (op == alu_pkg::OP_ADD_ACC_REGISTER
      || op == alu_pkg::OP_ADD_ACC_REG_CARRY) |=> mem_we_o && mem_waddr_o == $past(fa)
      && {carry_flag_o, mem_wdata_o} == $past(sum_reg) && $stable(acc_o)) else $error("add to reg");
   shift_acc_a: assert property (op_valid_i && op == alu_pkg::OP_ARITH_SHIFT_RIGHT && !op_req_i.dest
      |=> {carry_flag_o, acc_o} == $past(asr_val) && $stable(digit_carry_flag_o)) else $error("shift");
   bit_clr_a: assert property (op_valid_i && op == alu_pkg::OP_CLEAR_REGISTER_BIT
      |=> mem_we_o && mem_waddr_o == $past(fa) && mem_wdata_o == $past(clr_val) ##1 mem_we_o == $past(wr_req))
      else $error("bit clear");

   addc_c: cover property (op_valid_i && op == alu_pkg::OP_ADD_ACC_REG_CARRY && carry_flag_o);
   burst_c: cover property (op_valid_i && op_req_i.dest ##1 op_valid_i && op_req_i.dest);
   wrap_c: cover property (op_valid_i && op == alu_pkg::OP_POINTER_ADD_LITERAL && indirect_pointer_o[0] > 16'hfff0);
endmodule

bind accumulator_alu_ops accumulator_alu_ops_sva #(.NUM_PTR(NUM_PTR)) accumulator_alu_ops_sva_inst (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .op_valid_i(op_valid_i), .op_req_i(op_req_i), .mem_rdata_i(mem_rdata_i),
   .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o), .acc_o(acc_o),
   .carry_flag_o(carry_flag_o), .digit_carry_flag_o(digit_carry_flag_o), .zero_flag_o(zero_flag_o),
   .indirect_pointer_o(indirect_pointer_o), .s_axi_bvalid(s_axi_bvalid));

// ==== tb/data_memory_model.sv ====
// data memory behind the datapath: same-cycle read, clocked write
`timescale 1ns/1ps
module data_memory_model (
   input  wire logic       clk_i,
   input  wire logic [6:0] raddr_i,
   output logic      [7:0] rdata_o,
   input  wire logic       we_i,
   input  wire logic [6:0] waddr_i,
   input  wire logic [7:0] wdata_i
);
   logic [7:0] mem_q [128]; // one bank of 128 locations
   // fixed fill pattern so the bench model can mirror it
   initial begin
      for (int i = 0; i < 128; i++) mem_q[i] = 8'((i * 37 + 5) & 255);
   end
   // read follows the address at once; no forwarding of a pending write
   assign rdata_o = mem_q[raddr_i];
   always @(posedge clk_i) begin
      if (we_i) mem_q[waddr_i] <= wdata_i;
   end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench: random and directed ops against a reference model
`timescale 1ns/1ps
module testbench;
   logic             clk_i = 1'b0, sys_rst_i = 1'b1, op_valid_i = 1'b0;
   alu_pkg::op_req_t op_req_i = '0;
   logic [6:0]       mem_raddr_o, mem_waddr_o;
   logic [7:0]       mem_rdata_i, mem_wdata_o, acc_o, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic             mem_we_o, carry_flag_o, digit_carry_flag_o, zero_flag_o;
   logic [15:0]      indirect_pointer_o [2];
   logic [31:0]      s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0]       s_axi_bresp, s_axi_rresp;
   logic             s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic             s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int               n_mismatch = 0, compares = 0, acc, c, dc, z, opcnt, fa, last_wa = -1;
   int               ptr [2];
   int               mem [128];

   always #10 clk_i = ~clk_i;

   accumulator_alu_ops accumulator_alu_ops_inst (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .op_valid_i(op_valid_i), .op_req_i(op_req_i),
      .mem_raddr_o(mem_raddr_o), .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o),
      .mem_wdata_o(mem_wdata_o), .acc_o(acc_o), .carry_flag_o(carry_flag_o),
      .digit_carry_flag_o(digit_carry_flag_o), .zero_flag_o(zero_flag_o), .indirect_pointer_o(indirect_pointer_o),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   data_memory_model data_memory_model_inst (.clk_i(clk_i), .raddr_i(mem_raddr_o), .rdata_o(mem_rdata_i),
      .we_i(mem_we_o), .waddr_i(mem_waddr_o), .wdata_i(mem_wdata_o));

   // **********
   // drivers and reference model
   // **********
   task check(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task print_verdict();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // one bus access; release of each channel waits for its own ready
   task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] ex);
      bit ah, wh, rh, b;
      int n;
      logic [33:0] r;
      b = 0;
      n = 0;
      @(posedge clk_i);
      if (wr) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
      else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      while (!b && n < 20) begin
         @(negedge clk_i);
         {ah, wh, rh} = {s_axi_awready & s_axi_awvalid, s_axi_wready & s_axi_wvalid, s_axi_arready & s_axi_arvalid};
         b = wr ? s_axi_bvalid : s_axi_rvalid;
         r = wr ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
         n++;
         @(posedge clk_i);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
         if (rh) s_axi_arvalid <= 1'b0;
      end
      {s_axi_bready, s_axi_rready} <= 2'b00;
      check({29'h0, b, r}, {29'h0, 1'b1, ex});
   endtask

   // issue at the current edge; the model runs ahead, the compare lands a half cycle after the take
   task automatic issue(input int o, input int l, input int f, input int d, input int b, input int ps);
      int rv, s, cin, wr;
      logic [58:0] e, g;
      rv = mem[f];
      cin = (o == 7) ? c : 0;
      wr = 0;
      s = 0;
      op_valid_i <= 1'b1;
      op_req_i <= '{alu_pkg::op_t'(o), 8'(l), 7'(f), 1'(d), 3'(b), 1'(ps)};
      if (o == 1) ptr[ps] = (ptr[ps] + ((l & 63) ^ 32) - 32) & 65535;
      if (o == 2) acc = acc & l;
      if (o == 3) begin
         s = acc + l;
         c = s >> 8;
         dc = ((acc & 15) + (l & 15)) >> 4;
         acc = s & 255;
      end
      if (o == 2 || o == 3) z = (acc == 0);
      if (o == 4) s = acc & rv;
      if (o == 6) s = (rv >> 1) | (rv & 128);
      if (o == 6) c = rv & 1;
      if (o == 5 || o == 7) begin
         s = acc + rv + cin;
         c = s >> 8;
         dc = ((acc & 15) + (rv & 15) + cin) >> 4;
      end
      if (o == 8) s = rv & ~(1 << b);
      s = s & 255;
      if (o >= 4 && o <= 7) z = (s == 0);
      wr = (o == 8 || (o >= 4 && o <= 7 && d != 0));
      if (wr) mem[f] = s;
      else if (o >= 4 && o <= 7) acc = s;
      if (o != 0) opcnt++;
      last_wa = wr ? f : -1;
      e = {8'(acc), 1'(c), 1'(dc), 1'(z), 16'(ptr[0]), 16'(ptr[1]), 1'(wr), wr ? 7'(f) : 7'h0, wr ? 8'(s) : 8'h0};
      @(posedge clk_i);
      fork
         begin
            @(negedge clk_i);
            g = {acc_o, carry_flag_o, digit_carry_flag_o, zero_flag_o, indirect_pointer_o[0], indirect_pointer_o[1],
               mem_we_o, mem_we_o ? mem_waddr_o : 7'h0, mem_we_o ? mem_wdata_o : 8'h0};
            check({5'h0, g}, {5'h0, e});
         end
      join_none
   endtask

   // hang guard, well beyond the few hundred cycles the run needs
   initial begin
      repeat (8000) @(posedge clk_i);
      n_mismatch++;
      print_verdict();
   end

   initial begin
      void'($urandom(32'h3bb28967));
      for (int i = 0; i < 128; i++) mem[i] = (i * 37 + 5) & 255;
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      // reset values, unmapped place and read-only counter
      for (int i = 0; i < 6; i++) bus(0, 8'(i * 4), 32'h0, {(i == 5) ? alu_pkg::RESP_SLVERR : alu_pkg::RESP_OKAY, 32'h0});
      bus(1, alu_pkg::OPCNT_OFF, 32'h1234, {alu_pkg::RESP_SLVERR, 32'h0});
      bus(1, alu_pkg::STATUS_OFF, 32'hffffffff, {alu_pkg::RESP_OKAY, 32'h0});
      bus(0, alu_pkg::STATUS_OFF, 32'h0, {alu_pkg::RESP_OKAY, 32'h7});
      {c, dc, z} = {32'h1, 32'h1, 32'h1};
      bus(1, alu_pkg::PTR0_OFF, 32'hfffe, {alu_pkg::RESP_OKAY, 32'h0});
      bus(1, alu_pkg::PTR1_OFF, 32'h0010, {alu_pkg::RESP_OKAY, 32'h0});
      bus(1, alu_pkg::ACC_OFF, 32'h1f, {alu_pkg::RESP_OKAY, 32'h0});
      ptr[0] = 16'hfffe;
      ptr[1] = 16'h0010;
      acc = 31;
      // wrap over both ends and the literal limits, back to back with flags all set
      @(posedge clk_i);
      issue(1, 5, 0, 0, 0, 0);
      issue(1, 32, 0, 0, 0, 1);
      issue(1, 31, 0, 0, 0, 1);
      issue(8, 0, 3, 1, 2, 0);
      for (int i = 0; i < 400; i++) begin
         fa = $urandom_range(127);
         if (fa == last_wa) fa = fa ^ 1;
         issue($urandom_range(8), $urandom_range(255), fa, $urandom_range(1), $urandom_range(7), $urandom_range(1));
         if ($urandom_range(3) == 0) begin
            op_valid_i <= 1'b0;
            @(posedge clk_i);
         end
      end
      op_valid_i <= 1'b0;
      bus(0, alu_pkg::OPCNT_OFF, 32'h0, {alu_pkg::RESP_OKAY, 16'h0, 16'(opcnt)});
      bus(0, alu_pkg::ACC_OFF, 32'h0, {alu_pkg::RESP_OKAY, 24'h0, 8'(acc)});
      print_verdict();
   end
endmodule
